/* File: logic/scr_regs.sv */
/*
 Register slice of the sensor conditioner: temperature result readout
 with coherent high-byte holding, output code, output-stage capacitor
 switch, nonvolatile read window and two-byte programming buffer.
 Assumes host-port strobes and the converter result are synchronous to
 ref_clk_i; arst_n_i may be released at any time.
*/
// Overview of operation
// - Low-byte read captures upper byte into holding
// - High-byte read returns holding register content
// - Low register is LSB, high is MSB
// - Low byte shows live result bits 7..0, no reset
// - High byte shows bits 15..8, resets zero
// - Output code is 12 bits, low plus nibble
// - Stage control bit 4 closes capacitor switch
// - Nonvolatile bytes readable at page 5, 00-7F
// - Two read-write buffer bytes at 80, 81
// - Row select holds six-bit row address
// - Program bit writes buffer into selected row
// - Erase bit erases the selected row
// - Temperature low byte sits at page 0, 14
`timescale 1ns/1ps
module scr_regs (
   input  wire logic        ref_clk_i,         // 250 MHz clock
   input  wire logic        arst_n_i,          // Async reset, active low
   input  wire logic        host_port_wr_i,    // Write strobe, one cycle
   input  wire logic        host_port_rd_i,    // Read strobe, one cycle
   input  wire logic [2:0]  host_port_page_i,  // Page address
   input  wire logic [7:0]  host_port_ofs_i,   // Offset within page
   input  wire logic [7:0]  host_port_wdata_i, // Write data
   output logic      [7:0]  host_port_rdata_o, // Read data, registered
   output logic             host_port_rvalid_o,// Read data valid pulse
   input  wire logic [15:0] temp_conv_result_i,// Live converter output
   output logic      [11:0] output_code_o,     // Output DAC code
   output logic             output_cap_switch_o// Capacitor switch closed
);
   // ==========================================================
   // Reset release
   logic rst_meta_reg, rst_sync_reg;
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   wire logic rst_n = rst_sync_reg;

   function automatic logic hit(input logic [2:0] pg, input logic [7:0] of,
                                input logic [2:0] ep, input logic [7:0] eo);
      hit = (pg == ep) && (of == eo);
   endfunction

   // Row to byte index; upper picks the second byte of the row
   function automatic logic [scr_pkg::WINDOW_AW-1:0] row_byte(
      input logic [scr_pkg::ROW_W-1:0] row,
      input logic                      upper);
      row_byte = {row, upper};
   endfunction

   // Control byte image: only the switch bit is stored
   function automatic logic [7:0] stage_byte(input logic closed);
      stage_byte = scr_pkg::RESET_BYTE;
      stage_byte[scr_pkg::CAP_SW_BIT] = closed;
   endfunction

   // ==========================================================
   // Qualified strobes; requests inside the reset release are dropped
   logic wr_go;
   logic rd_go;

   always_comb begin
      wr_go = host_port_wr_i && rst_n;
      rd_go = host_port_rd_i && rst_n;
   end

   // ==========================================================
   // Address decode, one select per register, one for the whole window
   logic sel_temp_low;
   logic sel_temp_high;
   logic sel_code_low;
   logic sel_code_high;
   logic sel_stage_ctrl;
   logic sel_buf0;
   logic sel_buf1;
   logic sel_row;
   logic sel_nvm_ctrl;
   logic sel_window;

   always_comb begin
      sel_temp_low   = hit(host_port_page_i, host_port_ofs_i,
                           scr_pkg::PAGE_RESULT, scr_pkg::OFS_TEMP_LOW);
      sel_temp_high  = hit(host_port_page_i, host_port_ofs_i,
                           scr_pkg::PAGE_RESULT, scr_pkg::OFS_TEMP_HIGH);
      sel_code_low   = hit(host_port_page_i, host_port_ofs_i,
                           scr_pkg::PAGE_OUTPUT, scr_pkg::OFS_CODE_LOW);
      sel_code_high  = hit(host_port_page_i, host_port_ofs_i,
                           scr_pkg::PAGE_OUTPUT, scr_pkg::OFS_CODE_HIGH);
      sel_stage_ctrl = hit(host_port_page_i, host_port_ofs_i,
                           scr_pkg::PAGE_OUTPUT, scr_pkg::OFS_STAGE_CTRL);
      sel_buf0       = hit(host_port_page_i, host_port_ofs_i,
                           scr_pkg::PAGE_NVM, scr_pkg::OFS_BUF0);
      sel_buf1       = hit(host_port_page_i, host_port_ofs_i,
                           scr_pkg::PAGE_NVM, scr_pkg::OFS_BUF1);
      sel_row        = hit(host_port_page_i, host_port_ofs_i,
                           scr_pkg::PAGE_NVM, scr_pkg::OFS_ROW_SEL);
      sel_nvm_ctrl   = hit(host_port_page_i, host_port_ofs_i,
                           scr_pkg::PAGE_NVM, scr_pkg::OFS_NVM_CTRL);
      sel_window     = (host_port_page_i == scr_pkg::PAGE_NVM) &&
                       (host_port_ofs_i <= scr_pkg::OFS_WIN_LAST);
   end

   // ==========================================================
   // Temperature high-byte holding, refreshed by low-byte reads
   // A high read alone repeats the byte held by the last low read
   logic [7:0] temp_hold_reg;
   logic [7:0] temp_hold_next;

   always_comb begin
      temp_hold_next = temp_hold_reg;
      if (rd_go && sel_temp_low)
         temp_hold_next = temp_conv_result_i[15:8];
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n)
         temp_hold_reg <= scr_pkg::RESET_BYTE;
      else
         temp_hold_reg <= temp_hold_next;
   end

   // ==========================================================
   // Output code, low byte plus upper nibble
   logic [7:0]                      code_low_reg;
   logic [7:0]                      code_low_next;
   logic [scr_pkg::CODE_HIGH_W-1:0] code_high_reg;
   logic [scr_pkg::CODE_HIGH_W-1:0] code_high_next;

   always_comb begin
      code_low_next  = code_low_reg;
      code_high_next = code_high_reg;
      if (wr_go && sel_code_low)
         code_low_next = host_port_wdata_i;
      if (wr_go && sel_code_high)
         code_high_next =
            host_port_wdata_i[scr_pkg::CODE_HIGH_W-1:0];
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         code_low_reg  <= scr_pkg::RESET_BYTE;
         code_high_reg <= scr_pkg::RESET_BYTE[scr_pkg::CODE_HIGH_W-1:0];
      end else begin
         code_low_reg  <= code_low_next;
         code_high_reg <= code_high_next;
      end
   end

   // ==========================================================
   // Output-stage capacitor switch, closed while set
   logic cap_sw_reg;
   logic cap_sw_next;

   always_comb begin
      cap_sw_next = cap_sw_reg;
      if (wr_go && sel_stage_ctrl)
         cap_sw_next = host_port_wdata_i[scr_pkg::CAP_SW_BIT];
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n)
         cap_sw_reg <= scr_pkg::RESET_BYTE[scr_pkg::CAP_SW_BIT];
      else
         cap_sw_reg <= cap_sw_next;
   end

   // ==========================================================
   // Programming buffer and row select
   logic [7:0]                buf0_reg;
   logic [7:0]                buf0_next;
   logic [7:0]                buf1_reg;
   logic [7:0]                buf1_next;
   logic [scr_pkg::ROW_W-1:0] row_reg;
   logic [scr_pkg::ROW_W-1:0] row_next;

   always_comb begin
      buf0_next = buf0_reg;
      buf1_next = buf1_reg;
      row_next  = row_reg;
      if (wr_go && sel_buf0)
         buf0_next = host_port_wdata_i;
      if (wr_go && sel_buf1)
         buf1_next = host_port_wdata_i;
      if (wr_go && sel_row)
         row_next = host_port_wdata_i[scr_pkg::ROW_W-1:0];
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         buf0_reg <= scr_pkg::RESET_BYTE;
         buf1_reg <= scr_pkg::RESET_BYTE;
         row_reg  <= scr_pkg::RESET_BYTE[scr_pkg::ROW_W-1:0];
      end else begin
         buf0_reg <= buf0_next;
         buf1_reg <= buf1_next;
         row_reg  <= row_next;
      end
   end

   // ==========================================================
   // Control strobes; the control location itself stores nothing
   // Both requests last one cycle, no busy time is modelled
   logic prog_req;
   logic erase_req;

   always_comb begin
      prog_req  = 1'b0;
      erase_req = 1'b0;
      if (wr_go && sel_nvm_ctrl) begin
         prog_req  = host_port_wdata_i[scr_pkg::PROG_BIT];
         erase_req = host_port_wdata_i[scr_pkg::ERASE_BIT];
      end
   end

   // ==========================================================
   // Nonvolatile array, rows of two bytes, not reset
   // Contents stay undefined until a row is programmed or erased
   logic [7:0]                    nvm_mem [scr_pkg::NVM_WORDS];
   logic                          mem_we;
   logic [scr_pkg::WINDOW_AW-1:0] mem_addr0;
   logic [scr_pkg::WINDOW_AW-1:0] mem_addr1;
   logic [7:0]                    mem_data0;
   logic [7:0]                    mem_data1;

   // Erase wins when both bits are set, so a row is never half written
   always_comb begin
      mem_we    = erase_req || prog_req;
      mem_addr0 = row_byte(row_reg, 1'b0);
      mem_addr1 = row_byte(row_reg, 1'b1);
      mem_data0 = buf0_reg;
      mem_data1 = buf1_reg;
      if (erase_req) begin
         mem_data0 = scr_pkg::ERASED_BYTE;
         mem_data1 = scr_pkg::ERASED_BYTE;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (mem_we) begin
         nvm_mem[mem_addr0] <= mem_data0;
         nvm_mem[mem_addr1] <= mem_data1;
      end
   end

   // ==========================================================
   // Read data, registered, held until the next read
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       rvalid_reg;
   logic       rvalid_next;

   always_comb begin
      rdata_next  = rdata_reg;
      rvalid_next = rd_go;
      if (rd_go) begin
         // Unmapped locations and reserved bits read zero
         rdata_next = scr_pkg::RESET_BYTE;
         if (sel_window)
            rdata_next =
               nvm_mem[host_port_ofs_i[scr_pkg::WINDOW_AW-1:0]];
         else if (sel_temp_low)
            rdata_next = temp_conv_result_i[7:0];
         else if (sel_temp_high)
            rdata_next = temp_hold_reg;
         else if (sel_code_low)
            rdata_next = code_low_reg;
         else if (sel_code_high)
            rdata_next = 8'(code_high_reg);
         else if (sel_stage_ctrl)
            rdata_next = stage_byte(cap_sw_reg);
         else if (sel_buf0)
            rdata_next = buf0_reg;
         else if (sel_buf1)
            rdata_next = buf1_reg;
         else if (sel_row)
            rdata_next = 8'(row_reg);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg  <= scr_pkg::RESET_BYTE;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // ==========================================================
   // Outputs
   assign host_port_rdata_o   = rdata_reg;
   assign host_port_rvalid_o  = rvalid_reg;
   assign output_code_o       = {code_high_reg, code_low_reg};
   assign output_cap_switch_o = cap_sw_reg;
endmodule

/* File: include/scr_pkg.sv */
/*
 Constants for the sensor conditioner register slice: page and offset
 map, field positions, reset values and memory geometry.
 Assumes a host-port access of one byte at a page/offset pair.
*/
package scr_pkg;
   // ==========================================================
   // Pages
   localparam logic [2:0] PAGE_RESULT    = 3'h0;
   localparam logic [2:0] PAGE_OUTPUT    = 3'h2;
   localparam logic [2:0] PAGE_NVM       = 3'h5;
   // ==========================================================
   // Offsets
   localparam logic [7:0] OFS_TEMP_LOW   = 8'h14;
   localparam logic [7:0] OFS_TEMP_HIGH  = 8'h15;
   localparam logic [7:0] OFS_CODE_LOW   = 8'h30;
   localparam logic [7:0] OFS_CODE_HIGH  = 8'h31;
   localparam logic [7:0] OFS_STAGE_CTRL = 8'h3B;
   localparam logic [7:0] OFS_WIN_LAST   = 8'h7F;
   localparam logic [7:0] OFS_BUF0       = 8'h80;
   localparam logic [7:0] OFS_BUF1       = 8'h81;
   localparam logic [7:0] OFS_ROW_SEL    = 8'h82;
   localparam logic [7:0] OFS_NVM_CTRL   = 8'h83;
   // ==========================================================
   // Fields
   localparam int         CODE_HIGH_W    = 4;
   localparam int         ROW_W          = 6;
   localparam int         CAP_SW_BIT     = 4;
   localparam int         PROG_BIT       = 0;
   localparam int         ERASE_BIT      = 1;
   localparam int         WINDOW_AW      = 7;
   localparam int         NVM_WORDS      = 128;
   localparam logic [7:0] RESET_BYTE     = 8'h00;
   localparam logic [7:0] ERASED_BYTE    = 8'hFF;
endpackage

/* File: verification/scr_regs_sva.sv */
/* Port checker of the register slice.
 Assumes it is bound onto scr_regs and one clock. */
`timescale 1ns/1ps
module scr_regs_sva (
   input wire logic        ref_clk_i,
   input wire logic        arst_n_i,
   input wire logic        host_port_wr_i,
   input wire logic        host_port_rd_i,
   input wire logic [2:0]  host_port_page_i,
   input wire logic [7:0]  host_port_ofs_i,
   input wire logic [7:0]  host_port_wdata_i,
   input wire logic [7:0]  host_port_rdata_o,
   input wire logic        host_port_rvalid_o,
   input wire logic [15:0] temp_conv_result_i,
   input wire logic [11:0] output_code_o,
   input wire logic        output_cap_switch_o
);
   // ==========================================================
   // Decodes and captured result
   wire  [10:0] a  = {host_port_page_i, host_port_ofs_i};
   wire         lo = host_port_rd_i && a == 11'h014;
   wire         hi = host_port_rd_i && a == 11'h015;
   wire         wl = host_port_wr_i && a == 11'h230;
   wire         wh = host_port_wr_i && a == 11'h231;
   wire         wc = host_port_wr_i && a == 11'h23B;
   wire  [7:0]  d  = host_port_rdata_o;
   logic [15:0] cap_reg;
   logic [15:0] cap_next;
   always_comb cap_next = lo ? temp_conv_result_i : cap_reg;
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
      if (!arst_n_i) cap_reg <= 16'h0000;
      else cap_reg <= cap_next;
   // ==========================================================
   // Properties
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   chk_read_valid: assert property (host_port_rd_i |=> host_port_rvalid_o)
      else $error("read unanswered");
   chk_no_stray: assert property (!host_port_rd_i |=> !host_port_rvalid_o)
      else $error("stray valid");
   chk_low_byte: assert property (lo |=> d == cap_reg[7:0])
      else $error("low byte wrong");
   chk_high_byte: assert property (hi |=> d == cap_reg[15:8])
      else $error("high byte wrong");
   chk_code_low: assert property (
      wl |=> output_code_o[7:0] == $past(host_port_wdata_i))
      else $error("code low wrong");
   chk_code_high: assert property (
      wh |=> {4'h0, output_code_o[11:8]} ==
             ($past(host_port_wdata_i) & 8'h0F))
      else $error("code high wrong");
   chk_cap_set: assert property (
      wc |=> output_cap_switch_o == |($past(host_port_wdata_i) & 8'h10))
      else $error("switch wrong");
   chk_cap_hold: assert property (!wc |=> $stable(output_cap_switch_o))
      else $error("switch moved");
   cover property (lo ##2 hi);
   cover property (host_port_wr_i && a == 11'h583);
   cover property (host_port_rd_i && a >= 11'h500 && a < 11'h580);
endmodule
bind scr_regs scr_regs_sva i_chk (.*);

/* File: verification/scr_host.sv */
/* Host master model of the register port.
 Assumes strobes are taken on the rising clock edge. */
`timescale 1ns/1ps
module scr_host (
   input  wire logic       clk_i,
   output logic            wr_o,
   output logic            rd_o,
   output logic      [2:0] page_o,
   output logic      [7:0] ofs_o,
   output logic      [7:0] wdata_o,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rvalid_i
);
   initial {wr_o, rd_o, page_o, ofs_o, wdata_o} = '0;
   // One strobe cycle, address scrambled once released
   task automatic xfer(input logic w, input logic [10:0] a,
                       input logic [7:0] d, output logic [8:0] r);
      @(negedge clk_i);
      {wr_o, rd_o, page_o, ofs_o, wdata_o} = {w, !w, a, d};
      @(negedge clk_i);
      r = {rvalid_i, rdata_i};
      {wr_o, rd_o, page_o, ofs_o, wdata_o} = {2'b00, ~a, ~d};
   endtask
endmodule

/* File: verification/scr_regs_test.sv */
/* Testbench of the register slice against a behavioural model.
 Assumes the host model file and the bound checker. */
`timescale 1ns/1ps
module scr_regs_test;
   logic        ref_clk_i = 0, arst_n_i = 0, host_port_wr_i, host_port_rd_i;
   logic        host_port_rvalid_o, output_cap_switch_o;
   logic [2:0]  host_port_page_i;
   logic [7:0]  host_port_ofs_i, host_port_wdata_i, host_port_rdata_o;
   logic [15:0] temp_conv_result_i = 16'h0000;
   logic [11:0] output_code_o;
   logic [8:0]  x;
   int          bad_count = 0, cmp_count = 0, held = 0, row;
   int          m[2048] = '{default: 0}, nv[128] = '{default: 0};
   int          rl[9] = '{20, 21, 560, 561, 571, 1408, 1409, 1410, 0};
   int          wl[6] = '{560, 561, 571, 1408, 1409, 1410};
   always #2 ref_clk_i = ~ref_clk_i;
   scr_host i_host (.clk_i(ref_clk_i), .wr_o(host_port_wr_i),
      .rd_o(host_port_rd_i), .page_o(host_port_page_i),
      .ofs_o(host_port_ofs_i), .wdata_o(host_port_wdata_i),
      .rdata_i(host_port_rdata_o), .rvalid_i(host_port_rvalid_o));
   scr_regs i_dut (.*);
   // ==========================================================
   // Compare, write and read tasks
   task automatic chk(string n, int e, logic [11:0] s);
      cmp_count++;
      if (s !== 12'(e)) begin
         $display("BAD %s exp %h got %h", n, 12'(e), s);
         bad_count++;
      end
   endtask
   task automatic put(int k, int d);
      d = d & 255;
      i_host.xfer(1'b1, 11'(k), 8'(d), x);
      case (k)
         560, 1408, 1409: m[k] = d;
         561: m[k] = d & 15;
         571: m[k] = d & 16;
         1410: m[k] = d & 63;
         1411: for (int i = 0; i < 2; i++)
            if (d & 2) nv[m[1410] * 2 + i] = 255;
            else if (d & 1) nv[m[1410] * 2 + i] = m[1408 + i];
         default: ;
      endcase
      chk("code", m[561] * 256 + m[560], output_code_o);
      chk("switch", m[571] / 16, 12'(output_cap_switch_o));
   endtask
   task automatic get(int k);
      int e;
      e = k == 20 ? temp_conv_result_i[7:0] : k == 21 ? held : m[k];
      if (k == 20) held = temp_conv_result_i[15:8];
      if (k >= 1280 && k < 1408) e = nv[k - 1280];
      i_host.xfer(1'b0, 11'(k), 8'h00, x);
      chk("valid", 1, 12'(x[8]));
      chk($sformatf("reg %0h", k), e, 12'(x[7:0]));
   endtask
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========================================================
   // Sequence
   initial begin
      repeat (100000) @(posedge ref_clk_i);
      bad_count++;
      stop_test();
   end
   initial begin
      void'($urandom(1412));
      repeat (12) @(negedge ref_clk_i);
      arst_n_i = 1;
      repeat (2) @(negedge ref_clk_i);
      foreach (rl[i]) get(rl[i]);
      $display("reset test done");
      repeat (4) begin
         temp_conv_result_i = 16'($urandom);
         get(20);
         temp_conv_result_i = 16'($urandom);
         get(21);
         put(20, 255);
         get(21);
      end
      $display("result test done");
      repeat (3) foreach (wl[i]) begin
         put(wl[i], $urandom);
         get(wl[i]);
      end
      put(571, 16);
      put(571, 0);
      $display("control test done");
      repeat (3) begin
         put(1410, $urandom);
         row = m[1410] * 2 + 1280;
         put(1408, $urandom);
         put(1409, $urandom);
         put(1411, 2);
         get(row);
         put(1411, 1);
         get(row + 1);
         put(1408, $urandom);
         put(1411, 0);
         put(row, 0);
         get(row);
      end
      $display("memory test done");
      stop_test();
   end
endmodule
